//--- src/dram_mode_defs.vh
// constants for the dram mode-set and start-up block
// included by the mode-set top only; the latency decoder does not include it
`ifndef DRAM_MODE_DEFS_VH
`define DRAM_MODE_DEFS_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_TIMING 8'h08
`define OFS_STATUS 8'h0C

// control fields and reset value
`define CTRL_DECODE_EN 0
`define CTRL_CLR_INIT 1
`define CTRL_RESET 2'h1

// mode word field positions
`define MODE_CFG_LO 0
`define MODE_CFG_HI 2
`define MODE_BURST_LO 3
`define MODE_BURST_HI 4
`define MODE_ADDR_MUX 5
`define MODE_DLL 7
`define MODE_IMP 8
`define MODE_TERM 9
`define MODE_RESET 18'h00000

// timing word field positions
`define TIM_ROW_LO 0
`define TIM_READ_LO 8
`define TIM_WRITE_LO 16
`define TIM_RSVD 24

// status word field positions
`define ST_MUX 0
`define ST_DLL_ON 1
`define ST_DLL_LOCK 2
`define ST_IMP 3
`define ST_TERM 4
`define ST_READY 5
`define ST_BANKS_LO 8
`define ST_BURST_LO 16

// start-up and loop counts, in command clock cycles, and the all-banks refresh mask
`define NOP_COUNT 11'h400
`define DLL_LOCK_CYCLES 11'h400
`define BANKS_ALL 8'hFF

`endif

//--- src/latency_decode.v
// latency and row cycle decoder for the three-bit configuration field
// pure logic; the caller registers its outputs
`default_nettype none

module latency_decode (
  // configuration field and addressing mode
  input wire [2:0] cfg,
  input wire addr_mux,
  // decoded cycle counts
  output reg [3:0] row_cycle,
  output reg [3:0] read_lat,
  output reg [3:0] write_lat,
  output reg reserved
);

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    reserved = 1'b0;
    case (cfg)
      3'h0, 3'h1: begin
        row_cycle = 4'h4;
        read_lat = 4'h4;
      end
      3'h2: begin
        row_cycle = 4'h6;
        read_lat = 4'h6;
      end
      3'h3: begin
        row_cycle = 4'h8;
        read_lat = 4'h8;
      end
      3'h4: begin
        row_cycle = 4'h3;
        read_lat = 4'h3;
      end
      3'h5: begin
        row_cycle = 4'h5;
        read_lat = 4'h5;
      end
      default: begin
        row_cycle = 4'h0;
        read_lat = 4'h0;
        reserved = 1'b1;
      end
    endcase
    if (!reserved && addr_mux) begin
      read_lat = read_lat + 4'h1;
    end
    // write latency is read latency plus one, zero for reserved codes
    if (reserved) begin
      write_lat = 4'h0;
    end else begin
      write_lat = read_lat + 4'h1;
    end
  end

endmodule

`default_nettype wire

//--- src/dram_mode_ctrl.v
// mode-set capture, addressing mode and start-up tracking of a dram device
// command pins come from the external controller and are resynchronised;
// registers are reached over an ahb-lite slave with zero wait states
//
// Operation
// - address bit five high enters multiplexed mode
// - mode-set captures address bits zero to seventeen
// - decode config field into latency table
// - loop reset state turns loop off
// - mode-set sets addressing, loop, impedance, termination
// - multiplexed mode adds one latency cycle
// - multiplexed second address half follows next edge
`default_nettype none
`include "dram_mode_defs.vh"

module dram_mode_ctrl (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // command pins from the memory controller
  input wire chip_sel_n,
  input wire write_en_n,
  input wire refresh_n,
  input wire [2:0] bank_addr,
  input wire [17:0] addr,
  // operating configuration
  output reg [17:0] mode_r,
  output reg addr_mux_r,
  output reg dll_on_r,
  output reg dll_locked_r,
  output reg imp_match_r,
  output reg on_die_termination_enable_r,
  output reg [3:0] row_cycle_r,
  output reg [3:0] read_latency_cycles_r,
  output reg [3:0] write_latency_cycles_r,
  output reg cfg_reserved_r,
  output reg init_ready_r
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [23:0] pin_s1_r;
  reg [23:0] pin_s2_r;
  wire cs_n_s;
  wire we_n_s;
  wire ref_n_s;
  wire [2:0] bank_s;
  wire [17:0] addr_s;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 24'hE00000;
      pin_s2_r <= 24'hE00000;
    end else begin
      pin_s1_r <= {chip_sel_n, write_en_n, refresh_n, bank_addr, addr};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign cs_n_s = pin_s2_r[23];
  assign we_n_s = pin_s2_r[22];
  assign ref_n_s = pin_s2_r[21];
  assign bank_s = pin_s2_r[20:18];
  assign addr_s = pin_s2_r[17:0];

  ////////////////////////////////////////////////////////////////////////
  // command decode
  reg [1:0] ctrl_r;
  wire decode_en;
  wire is_mode_set;
  wire is_refresh;
  wire is_nop;
  assign decode_en = ctrl_r[`CTRL_DECODE_EN];
  assign is_mode_set = decode_en && !cs_n_s && !we_n_s && !ref_n_s;
  assign is_refresh = decode_en && !cs_n_s && we_n_s && !ref_n_s;
  assign is_nop = decode_en && cs_n_s;
  // bank one-hot for refresh tracking
  function [7:0] bank_bit;
    input [2:0] b;
    begin
      bank_bit = 8'h01 << b;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode capture; two-cycle form in multiplexed mode
  localparam [1:0] CAP_IDLE = 2'b01;
  localparam [1:0] CAP_SECOND = 2'b10;
  reg [1:0] cap_state_r;
  reg [17:0] first_half_r;
  wire [17:0] mux_word;
  assign mux_word = {first_half_r[17:10], first_half_r[9], first_half_r[8],
    addr_s[9], addr_s[8], first_half_r[5], first_half_r[4], first_half_r[3],
    addr_s[4], addr_s[3], first_half_r[0]};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_state_r <= CAP_IDLE;
      first_half_r <= 18'h00000;
      mode_r <= `MODE_RESET;
    end else begin
      case (cap_state_r)
        CAP_IDLE: begin
          if (is_mode_set && addr_mux_r) begin
            first_half_r <= addr_s;
            cap_state_r <= CAP_SECOND;
          end else if (is_mode_set) begin
            mode_r <= addr_s;
          end
        end
        CAP_SECOND: begin
          mode_r <= mux_word;
          cap_state_r <= CAP_IDLE;
        end
        default: begin
          cap_state_r <= CAP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // features steered by the mode word
  wire [3:0] row_cycle_d;
  wire [3:0] read_lat_d;
  wire [3:0] write_lat_d;
  wire reserved_d;
  reg [10:0] dll_count_r;
  latency_decode decode_u (
    .cfg(mode_r[`MODE_CFG_HI:`MODE_CFG_LO]),
    .addr_mux(addr_mux_r),
    .row_cycle(row_cycle_d),
    .read_lat(read_lat_d),
    .write_lat(write_lat_d),
    .reserved(reserved_d)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_mux_r <= 1'b0;
      dll_on_r <= 1'b0;
      dll_locked_r <= 1'b0;
      dll_count_r <= 11'h000;
      imp_match_r <= 1'b0;
      on_die_termination_enable_r <= 1'b0;
      row_cycle_r <= 4'h0;
      read_latency_cycles_r <= 4'h0;
      write_latency_cycles_r <= 4'h0;
      cfg_reserved_r <= 1'b0;
    end else begin
      addr_mux_r <= mode_r[`MODE_ADDR_MUX];
      imp_match_r <= mode_r[`MODE_IMP];
      on_die_termination_enable_r <= mode_r[`MODE_TERM];
      dll_on_r <= mode_r[`MODE_DLL];
      if (!mode_r[`MODE_DLL]) begin
        dll_count_r <= 11'h000;
        dll_locked_r <= 1'b0;
      end else if (dll_count_r != `DLL_LOCK_CYCLES) begin
        dll_count_r <= dll_count_r + 11'h001;
      end else begin
        dll_locked_r <= 1'b1;
      end
      row_cycle_r <= row_cycle_d;
      read_latency_cycles_r <= read_lat_d;
      write_latency_cycles_r <= write_lat_d;
      cfg_reserved_r <= reserved_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start-up tracking as seen from the pins
  reg mode_seen_r;
  reg [7:0] banks_r;
  reg [10:0] nop_count_r;
  wire clr_init;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_seen_r <= 1'b0;
      banks_r <= 8'h00;
      nop_count_r <= 11'h000;
      init_ready_r <= 1'b0;
    end else if (clr_init) begin
      mode_seen_r <= 1'b0;
      banks_r <= 8'h00;
      nop_count_r <= 11'h000;
      init_ready_r <= 1'b0;
    end else begin
      if (is_mode_set) begin
        mode_seen_r <= 1'b1;
      end
      // refresh per bank and no-op count
      if (mode_seen_r && is_refresh) begin
        banks_r <= banks_r | bank_bit(bank_s);
      end
      if (mode_seen_r && is_nop && nop_count_r != `NOP_COUNT) begin
        nop_count_r <= nop_count_r + 11'h001;
      end
      if (banks_r == `BANKS_ALL && nop_count_r == `NOP_COUNT) begin
        init_ready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire take;
  reg [31:0] rd_nxt;
  assign take = hsel && htrans[1] && hready;
  assign clr_init = wr_pend_r && wr_addr_r == `OFS_CTRL && hwdata[`CTRL_CLR_INIT];
  always @* begin
    rd_nxt = 32'h00000000;
    case (haddr)
      `OFS_CTRL: rd_nxt[1:0] = ctrl_r;
      `OFS_MODE: rd_nxt[17:0] = mode_r;
      `OFS_TIMING: begin
        rd_nxt[`TIM_ROW_LO +: 4] = row_cycle_r;
        rd_nxt[`TIM_READ_LO +: 4] = read_latency_cycles_r;
        rd_nxt[`TIM_WRITE_LO +: 4] = write_latency_cycles_r;
        rd_nxt[`TIM_RSVD] = cfg_reserved_r;
      end
      `OFS_STATUS: begin
        rd_nxt[`ST_MUX] = addr_mux_r;
        rd_nxt[`ST_DLL_ON] = dll_on_r;
        rd_nxt[`ST_DLL_LOCK] = dll_locked_r;
        rd_nxt[`ST_IMP] = imp_match_r;
        rd_nxt[`ST_TERM] = on_die_termination_enable_r;
        rd_nxt[`ST_READY] = init_ready_r;
        rd_nxt[`ST_BANKS_LO +: 8] = banks_r;
        rd_nxt[`ST_BURST_LO +: 2] = mode_r[`MODE_BURST_HI:`MODE_BURST_LO];
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      ctrl_r <= `CTRL_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= take && hwrite;
      if (take) begin
        wr_addr_r <= haddr;
      end
      if (take && !hwrite) begin
        hrdata <= rd_nxt;
      end
      // clear bit is a pulse and is not kept
      if (wr_pend_r && wr_addr_r == `OFS_CTRL) begin
        ctrl_r <= {1'b0, hwdata[`CTRL_DECODE_EN]};
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/dram_mode_checker.sv
// assertions on the dram mode-set block
// sees only top-level ports; bound from the testbench
`default_nettype none
module dram_mode_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // command pins
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic refresh_n,
  input wire logic [17:0] addr,
  // configuration
  input wire logic [17:0] mode_r,
  input wire logic addr_mux_r,
  input wire logic dll_on_r,
  input wire logic imp_match_r,
  input wire logic on_die_termination_enable_r,
  input wire logic [3:0] row_cycle_r,
  input wire logic [3:0] read_latency_cycles_r,
  input wire logic [3:0] write_latency_cycles_r,
  input wire logic cfg_reserved_r,
  input wire logic init_ready_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic up_r;
  wire ms = !chip_sel_n && !write_en_n && !refresh_n;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_r <= 1'b0;
    else up_r <= 1'b1;
  end
  function automatic logic [3:0] rc(input logic [2:0] x);
    case (x)
      3'h2: return 4'h6;
      3'h3: return 4'h8;
      3'h4: return 4'h3;
      3'h5: return 4'h5;
      3'h6, 3'h7: return 4'h0;
      default: return 4'h4;
    endcase
  endfunction
  function automatic logic [3:0] lat(input logic [2:0] x, input logic [1:0] e);
    return (rc(x) == 4'h0) ? 4'h0 : rc(x) + {2'h0, e};
  endfunction
  property p_cap;
    $changed(mode_r) && !addr_mux_r |-> $past(ms, 3) && mode_r == $past(addr, 3);
  endproperty
  a_cap: assert property (p_cap) else $error("mode word not from pins");
  property p_row;
    up_r |-> row_cycle_r == rc($past(mode_r[2:0]));
  endproperty
  a_row: assert property (p_row) else $error("row cycle wrong");
  property p_rd;
    up_r |-> read_latency_cycles_r == lat($past(mode_r[2:0]), {1'b0, $past(addr_mux_r)});
  endproperty
  a_rd: assert property (p_rd) else $error("read latency wrong");
  property p_wr;
    up_r |-> write_latency_cycles_r
      == lat($past(mode_r[2:0]), {1'b0, $past(addr_mux_r)} + 2'h1);
  endproperty
  a_wr: assert property (p_wr) else $error("write latency wrong");
  property p_rsv;
    cfg_reserved_r == &$past(mode_r[2:1]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_mux;
    $rose(mode_r[5]) |=> addr_mux_r;
  endproperty
  a_mux: assert property (p_mux) else $error("mux mode not entered");
  property p_feat;
    {on_die_termination_enable_r, imp_match_r} == $past(mode_r[9:8]);
  endproperty
  a_feat: assert property (p_feat) else $error("feature enables wrong");
  property p_dll;
    dll_on_r == $past(mode_r[7]);
  endproperty
  a_dll: assert property (p_dll) else $error("loop enable wrong");
  c_ms: cover property (ms ##1 ms ##1 ms);
  c_rdy: cover property ($rose(init_ready_r));
  c_mux: cover property ($rose(addr_mux_r));
endmodule
`default_nettype wire

//--- testbench/dram_cmd_host.sv
// memory controller model driving the command pins
// clocked by hclk; the testbench calls its tasks
`default_nettype none
module dram_cmd_host (
  // clock
  input wire logic hclk,
  // command pins
  output logic chip_sel_n,
  output logic write_en_n,
  output logic refresh_n,
  output logic [2:0] bank_addr,
  output logic [17:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {chip_sel_n, write_en_n, refresh_n} = 3'h7;
    bank_addr = 3'h0;
    addr = 18'h00000;
  end
  task automatic put(input logic [2:0] c, input logic [2:0] b, input logic [17:0] a);
    @(posedge hclk);
    {chip_sel_n, write_en_n, refresh_n} <= c;
    bank_addr <= b;
    addr <= a;
  endtask
  task automatic no_operation_command(input int n);
    repeat (n) put(3'h7, ~bank_addr, ~addr);
  endtask
  task automatic mode_set(input logic [17:0] a);
    put(3'h0, 3'h0, a);
  endtask
  task automatic mode_set_mux(input logic [17:0] first_half, input logic [17:0] second_half);
    put(3'h0, 3'h0, first_half);
    put(3'h7, 3'h0, second_half);
  endtask
  // bank refresh, never same bank twice
  task automatic refr(input logic [2:0] b);
    put(3'h2, b, ~addr);
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the dram mode-set block
// ahb-lite master here; command pins from the controller model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready, hreadyout, hresp, chip_sel_n, write_en_n, refresh_n;
  logic [31:0] hrdata;
  logic [2:0] bank_addr;
  logic [17:0] addr, mode_r;
  logic addr_mux_r, dll_on_r, dll_locked_r, imp_match_r, on_die_termination_enable_r;
  logic cfg_reserved_r, init_ready_r;
  logic [3:0] row_cycle_r, read_latency_cycles_r, write_latency_cycles_r;
  int errors = 0;
  int n_tests = 0;
  logic [3:0] rows [8] = '{4'h4, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5, 4'h0, 4'h0};
  assign hready = hreadyout;
  dram_mode_ctrl i_dram_mode_ctrl (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .chip_sel_n(chip_sel_n),
    .write_en_n(write_en_n),
    .refresh_n(refresh_n),
    .bank_addr(bank_addr),
    .addr(addr),
    .mode_r(mode_r),
    .addr_mux_r(addr_mux_r),
    .dll_on_r(dll_on_r),
    .dll_locked_r(dll_locked_r),
    .imp_match_r(imp_match_r),
    .on_die_termination_enable_r(on_die_termination_enable_r),
    .row_cycle_r(row_cycle_r),
    .read_latency_cycles_r(read_latency_cycles_r),
    .write_latency_cycles_r(write_latency_cycles_r),
    .cfg_reserved_r(cfg_reserved_r),
    .init_ready_r(init_ready_r)
  );
  dram_cmd_host i_dram_cmd_host (
    .hclk(hclk),
    .chip_sel_n(chip_sel_n),
    .write_en_n(write_en_n),
    .refresh_n(refresh_n),
    .bank_addr(bank_addr),
    .addr(addr)
  );
  always #5 hclk = ~hclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    chk({31'h0, hresp}, 32'h0);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask
  function automatic logic [31:0] tim(input logic [2:0] c, input logic m);
    logic [3:0] r;
    r = rows[c];
    if (r == 4'h0) return 32'h01000000;
    return {12'h0, r + 4'h1 + m, 4'h0, r + m, 4'h0, r};
  endfunction
  task automatic ms(input logic [17:0] a);
    i_dram_cmd_host.mode_set(a);
    i_dram_cmd_host.no_operation_command(6);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rchk(8'h08, 32'h00050404);
    rchk(8'h0C, 32'h0);
    wr(8'h04, 32'h3FF);
    rchk(8'h04, 32'h0);
    rchk(8'h10, 32'h0);
  endtask
  task automatic t_startup;
    i_dram_cmd_host.no_operation_command(20000);
    i_dram_cmd_host.mode_set(18'h0);
    i_dram_cmd_host.mode_set(18'h0);
    ms(18'h00382);
    rchk(8'h0C, 32'h0000001A);
    for (int b = 0; b < 7; b++) i_dram_cmd_host.refr(b[2:0]);
    i_dram_cmd_host.no_operation_command(1100);
    rchk(8'h0C, 32'h00007F1E);
    i_dram_cmd_host.refr(3'h7);
    i_dram_cmd_host.no_operation_command(6);
    rchk(8'h0C, 32'h0000FF3E);
    rchk(8'h04, 32'h00000382);
  endtask
  task automatic t_cfg;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      // reserved codes 6 and 7 expect the flag with all timing fields zero
      ms({13'h0, c[1:0], c});
      rchk(8'h08, tim(c, 1'b0));
    end
    chk({31'h0, dll_on_r}, 32'h0);
    wr(8'h00, 32'h0);
    ms(18'h00005);
    rchk(8'h04, 32'h0000001F);
    wr(8'h00, 32'h1);
  endtask
  task automatic t_mux;
    ms(18'h00021);
    rchk(8'h08, tim(3'h1, 1'b1));
    i_dram_cmd_host.mode_set_mux(18'h00021, 18'h00008);
    i_dram_cmd_host.no_operation_command(6);
    rchk(8'h04, 32'h00000023);
    rchk(8'h08, 32'h000A0908);
    wr(8'h00, 32'h3);
    rchk(8'h0C, 32'h00000001);
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_startup;
    t_cfg;
    t_mux;
    complete_run;
  end
  initial begin
    #400us;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run;
  end
endmodule
bind dram_mode_ctrl dram_mode_checker i_dram_mode_checker (
  .hclk(hclk),
  .hresetn(hresetn),
  .chip_sel_n(chip_sel_n),
  .write_en_n(write_en_n),
  .refresh_n(refresh_n),
  .addr(addr),
  .mode_r(mode_r),
  .addr_mux_r(addr_mux_r),
  .dll_on_r(dll_on_r),
  .imp_match_r(imp_match_r),
  .on_die_termination_enable_r(on_die_termination_enable_r),
  .row_cycle_r(row_cycle_r),
  .read_latency_cycles_r(read_latency_cycles_r),
  .write_latency_cycles_r(write_latency_cycles_r),
  .cfg_reserved_r(cfg_reserved_r),
  .init_ready_r(init_ready_r)
);
`default_nettype wire
